// >>> hw/scm_pkg.sv
// scm_pkg: constants, types and states of the set-up mode controller
// assumes a single 25 MHz clock and a synchronous active-high reset
package scm_pkg;
    localparam int unsigned CLK_HZ      = 25_000_000;
    localparam int unsigned MS_DIV      = CLK_HZ / 1000;
    localparam int unsigned ENTRY_MS    = 3000;
    localparam int unsigned CPT_SHORT_MS = 500;
    localparam int unsigned CPT_LONG_MS = 5000;
    localparam int unsigned RELAY_MS    = 100;
    localparam int unsigned TONE_PER_MS = 1000;
    localparam int unsigned NEAR_ON_MS  = 950;
    localparam int unsigned LOW_ON_MS   = 100;
    localparam int unsigned CDLY_MAX_S  = 12;
    localparam int unsigned DWELL_MUL   = 6;
    localparam int unsigned SPD_FULL    = 255;
    localparam logic [24:0] ACC_STEP    = 25'(DWELL_MUL * SPD_FULL);
    // switch patterns
    localparam logic [6:0] SEL_NONE     = 7'h00;
    localparam logic [6:0] SEL_SCREWS   = 7'h01;
    localparam logic [6:0] SEL_CPT_SHRT = 7'h02;
    localparam logic [6:0] SEL_CPT_LONG = 7'h06;
    localparam logic [6:0] SEL_CDLY     = 7'h0A;
    // register map
    localparam logic [7:0] REG_STATUS   = 8'h00;
    localparam logic [7:0] REG_PARAM    = 8'h04;
    localparam logic [7:0] REG_CTRL     = 8'h08;
    // lever direction codes
    localparam logic [1:0] DIR_NEUT     = 2'h0;
    localparam logic [1:0] DIR_AHEAD    = 2'h1;
    localparam logic [1:0] DIR_ASTERN   = 2'h2;
    typedef struct packed {
        logic [1:0] screws;
        logic       cpt_long;
        logic [3:0] delay_s;
    } scm_cfg_t;
    localparam scm_cfg_t CFG_DEF = '{screws: 2'h0, cpt_long: 1'b1, delay_s: 4'h0};
    typedef enum logic [4:0] {
        ST_RUN   = 5'h01,
        ST_ENTRY = 5'h02,
        ST_SETUP = 5'h04,
        ST_FAULT = 5'h08,
        ST_EXIT  = 5'h10
    } scm_state_t;
    typedef struct packed {
        logic tone;
        logic lamp;
        logic run_led;
        logic relay;
    } scm_ind_t;
endpackage : scm_pkg

// >>> hw/scm_top.sv
// scm_top: set-up mode entry/exit, switch validation, parameter store,
// clutch pressure window and reversal pause on the throttle path
// assumes all inputs synchronous to sys_clk; levers give direction and speed
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
module scm_top #(
    parameter int unsigned MS_DIV = scm_pkg::MS_DIV
) (
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire logic [6:0]           config_switch_bank,
    input  wire logic                 setup_jumper,
    input  wire logic                 store_pushbutton,
    input  wire logic [7:0]           adjust_potentiometer,
    input  wire logic                 station_cmd,
    input  wire logic [1:0]           lever_dir,
    input  wire logic [7:0]           lever_speed,
    input  wire logic                 clutch_sw_fitted,
    input  wire logic                 clutch_sw_closed,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output scm_pkg::scm_ind_t         ind_q,
    output logic                      run_state_q,
    output logic [7:0]                throttle_q,
    output logic [1:0]                gear_q,
    output scm_pkg::scm_cfg_t         cfg_q,
    output logic [31:0]               reg_rdata_q
);
    scm_pkg::scm_state_t st_q;
    scm_pkg::scm_state_t st_d;
    logic [15:0]         div_q;
    logic                tick;
    logic [9:0]          ph_q;
    logic [11:0]         ent_q;
    logic [6:0]          rly_q;
    logic                click_q;
    logic                jmp_q;
    logic                pb_q;
    logic                sel_ok;
    logic                store_ok;
    logic [12:0]         cpt_q;
    logic [24:0]         acc_q;
    logic [24:0]         acc_cap;
    logic [1:0]          dir_q;
    logic                pz_q;
    logic                half_q;
    logic [12:0]         window;
    logic                cpt_out;

    function automatic logic pattern_valid(input logic [6:0] p);
        pattern_valid = (p == scm_pkg::SEL_SCREWS) || (p == scm_pkg::SEL_CPT_SHRT) ||
                        (p == scm_pkg::SEL_CPT_LONG) || (p == scm_pkg::SEL_CDLY);
    endfunction : pattern_valid

    assign tick     = (div_q == 16'(MS_DIV - 1));
    assign sel_ok   = pattern_valid(config_switch_bank);
    assign store_ok = store_pushbutton && !pb_q && (st_q == scm_pkg::ST_SETUP) && sel_ok;
    assign window   = cfg_q.cpt_long ? 13'(scm_pkg::CPT_LONG_MS) : 13'(scm_pkg::CPT_SHORT_MS);
    assign acc_cap  = 25'(cfg_q.delay_s) * 25'd1000 * scm_pkg::ACC_STEP;
    assign cpt_out  = clutch_sw_fitted && !clutch_sw_closed && (lever_dir != scm_pkg::DIR_NEUT)
                      && (cpt_q >= window);

    // millisecond enable and tone phase
    always_ff @(posedge sys_clk) begin
        if (reset || tick) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ph_q <= 10'h000;
        end else if (tick) begin
            ph_q <= (ph_q == 10'(scm_pkg::TONE_PER_MS - 1)) ? 10'h000 : ph_q + 10'h001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            jmp_q <= 1'b0;
            pb_q  <= 1'b0;
        end else begin
            jmp_q <= setup_jumper;
            pb_q  <= store_pushbutton;
        end
    end

    // mode sequencing
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            scm_pkg::ST_RUN: begin
                if (setup_jumper && !jmp_q) begin
                    st_d = (config_switch_bank == scm_pkg::SEL_NONE) ? scm_pkg::ST_ENTRY
                                                                     : scm_pkg::ST_FAULT;
                end
            end
            scm_pkg::ST_ENTRY: begin
                if (!setup_jumper) begin
                    st_d = scm_pkg::ST_EXIT;
                end else if (tick && ent_q == 12'(scm_pkg::ENTRY_MS - 1)) begin
                    st_d = scm_pkg::ST_SETUP;
                end
            end
            scm_pkg::ST_SETUP: begin
                if (!setup_jumper) begin
                    st_d = scm_pkg::ST_EXIT;
                end
            end
            scm_pkg::ST_FAULT: begin
                if (!setup_jumper && config_switch_bank == scm_pkg::SEL_NONE) begin
                    st_d = scm_pkg::ST_EXIT;
                end
            end
            scm_pkg::ST_EXIT: begin
                if (station_cmd) begin
                    st_d = scm_pkg::ST_RUN;
                end
            end
            default: st_d = scm_pkg::ST_EXIT;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_q <= scm_pkg::ST_RUN;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || st_q != scm_pkg::ST_ENTRY) begin
            ent_q <= 12'h000;
        end else if (tick) begin
            ent_q <= ent_q + 12'h001;
        end
    end

    // parameter store
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cfg_q <= scm_pkg::CFG_DEF;
        end else if (reg_wr && reg_addr == scm_pkg::REG_CTRL && reg_wdata[0]) begin
            cfg_q <= scm_pkg::CFG_DEF;
        end else if (store_ok) begin
            unique case (config_switch_bank)
                scm_pkg::SEL_SCREWS:   cfg_q.screws   <= adjust_potentiometer[7:6];
                scm_pkg::SEL_CPT_SHRT: cfg_q.cpt_long <= 1'b0;
                scm_pkg::SEL_CPT_LONG: cfg_q.cpt_long <= 1'b1;
                default: begin
                    cfg_q.delay_s <= (adjust_potentiometer[7:4] > 4'(scm_pkg::CDLY_MAX_S)) ?
                                     4'(scm_pkg::CDLY_MAX_S) : adjust_potentiometer[7:4];
                end
            endcase
        end
    end

    // relay: single confirm pulse, or clicking while in error
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rly_q <= 7'h00;
        end else if (store_ok) begin
            rly_q <= 7'(scm_pkg::RELAY_MS);
        end else if (tick && rly_q != 7'h00) begin
            rly_q <= rly_q - 7'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            click_q <= 1'b0;
        end else if (tick && ph_q[7:0] == 8'h00) begin
            click_q <= !click_q;
        end
    end

    // indicators
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ind_q <= '0;
        end else begin
            ind_q.lamp    <= station_cmd && (st_q == scm_pkg::ST_RUN);
            ind_q.run_led <= (st_q != scm_pkg::ST_ENTRY);
            unique case (st_q)
                scm_pkg::ST_ENTRY: ind_q.tone <= 1'b1;
                scm_pkg::ST_FAULT: ind_q.tone <= ph_q < 10'(scm_pkg::NEAR_ON_MS);
                scm_pkg::ST_SETUP: ind_q.tone <= (config_switch_bank != scm_pkg::SEL_NONE) && !sel_ok
                                                 && ph_q < 10'(scm_pkg::NEAR_ON_MS);
                scm_pkg::ST_EXIT:  ind_q.tone <= ph_q < 10'(scm_pkg::LOW_ON_MS);
                default:           ind_q.tone <= 1'b0;
            endcase
            if (rly_q != 7'h00) begin
                ind_q.relay <= 1'b1;
            end else if (st_q == scm_pkg::ST_FAULT || (st_q == scm_pkg::ST_SETUP &&
                         config_switch_bank != scm_pkg::SEL_NONE && !sel_ok)) begin
                ind_q.relay <= click_q;
            end else begin
                ind_q.relay <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            run_state_q <= 1'b1;
        end else begin
            run_state_q <= (config_switch_bank == scm_pkg::SEL_NONE) && !setup_jumper;
        end
    end

    // clutch pressure window
    always_ff @(posedge sys_clk) begin
        if (reset || clutch_sw_closed || lever_dir == scm_pkg::DIR_NEUT) begin
            cpt_q <= 13'h0000;
        end else if (tick && cpt_q < window) begin
            cpt_q <= cpt_q + 13'h0001;
        end
    end

    // reversal pause: charge grows with speed and dwell, drains during pause
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            acc_q  <= 25'h0000000;
            dir_q  <= scm_pkg::DIR_NEUT;
            pz_q   <= 1'b0;
            half_q <= 1'b0;
        end else if (pz_q) begin
            if (tick) begin
                if (acc_q <= (half_q ? ACC_STEP2() : scm_pkg::ACC_STEP)) begin
                    acc_q <= 25'h0000000;
                    pz_q  <= 1'b0;
                    dir_q <= lever_dir;
                end else begin
                    acc_q <= acc_q - (half_q ? ACC_STEP2() : scm_pkg::ACC_STEP);
                end
            end
        end else if (lever_dir != dir_q && lever_dir != scm_pkg::DIR_NEUT &&
                     dir_q != scm_pkg::DIR_NEUT) begin
            pz_q   <= (acc_q != 25'h0000000);
            half_q <= (dir_q == scm_pkg::DIR_ASTERN);
            if (acc_q == 25'h0000000) begin
                dir_q <= lever_dir;
            end
        end else begin
            if (lever_dir != scm_pkg::DIR_NEUT) begin
                dir_q <= lever_dir;
            end
            if (lever_speed == 8'h00) begin
                acc_q <= 25'h0000000;
            end else if (acc_q > acc_cap) begin
                acc_q <= acc_cap;
            end else if (tick) begin
                acc_q <= (acc_q + 25'(lever_speed) > acc_cap) ? acc_cap
                                                               : acc_q + 25'(lever_speed);
            end
        end
    end

    function automatic logic [24:0] ACC_STEP2();
        ACC_STEP2 = 25'(2 * scm_pkg::ACC_STEP);
    endfunction : ACC_STEP2

    // throttle and gear outputs
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            throttle_q <= 8'h00;
            gear_q     <= scm_pkg::DIR_NEUT;
        end else begin
            gear_q <= pz_q ? dir_q : lever_dir;
            if (pz_q || cpt_out || st_q != scm_pkg::ST_RUN) begin
                throttle_q <= 8'h00;
            end else begin
                throttle_q <= lever_speed;
            end
        end
    end

    // register read port
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata_q <= 32'h00000000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                scm_pkg::REG_STATUS: reg_rdata_q <= {24'h000000, pz_q, sel_ok, run_state_q, st_q};
                scm_pkg::REG_PARAM:  reg_rdata_q <= {25'h0000000, cfg_q};
                default:             reg_rdata_q <= 32'h00000000;
            endcase
        end else begin
            reg_rdata_q <= 32'h00000000;
        end
    end

    property p_entry_tone;
        @(posedge sys_clk) disable iff (reset)
        st_q == scm_pkg::ST_ENTRY |=> ind_q.tone && !ind_q.lamp;
    endproperty
    a_entry_tone: assert property (p_entry_tone) else $error("entry tone or lamp wrong");

    property p_entry_led;
        @(posedge sys_clk) disable iff (reset)
        $rose(st_q == scm_pkg::ST_ENTRY) |=> !ind_q.run_led [*8];
    endproperty
    a_entry_led: assert property (p_entry_led) else $error("run led lit at entry");

    property p_store_pulse;
        @(posedge sys_clk) disable iff (reset)
        store_ok |-> ##2 ind_q.relay;
    endproperty
    a_store_pulse: assert property (p_store_pulse) else $error("no confirm pulse");

    property p_store_ignored;
        @(posedge sys_clk) disable iff (reset)
        store_pushbutton && !pb_q && !sel_ok && !reg_wr |=> $stable(cfg_q);
    endproperty
    a_store_ignored: assert property (p_store_ignored) else $error("bad store changed cfg");

    property p_exit;
        @(posedge sys_clk) disable iff (reset)
        st_q == scm_pkg::ST_SETUP && !setup_jumper |=> st_q == scm_pkg::ST_EXIT;
    endproperty
    a_exit: assert property (p_exit) else $error("set-up not left on jumper open");

    property p_cpt_idle;
        @(posedge sys_clk) disable iff (reset)
        cpt_out |=> throttle_q == 8'h00;
    endproperty
    a_cpt_idle: assert property (p_cpt_idle) else $error("throttle above idle after window");

    property p_pause_idle;
        @(posedge sys_clk) disable iff (reset)
        pz_q |=> throttle_q == 8'h00 && gear_q == $past(dir_q);
    endproperty
    a_pause_idle: assert property (p_pause_idle) else $error("throttle during pause");

    property p_zero_pause;
        @(posedge sys_clk) disable iff (reset)
        !pz_q && acc_q == 25'h0000000 |=> !pz_q;
    endproperty
    a_zero_pause: assert property (p_zero_pause) else $error("pause with no charge");

    property p_run_state;
        @(posedge sys_clk) disable iff (reset)
        config_switch_bank != scm_pkg::SEL_NONE |=> !run_state_q;
    endproperty
    a_run_state: assert property (p_run_state) else $error("run state with switch on");

    property p_cap;
        @(posedge sys_clk) disable iff (reset)
        !pz_q |-> acc_q <= acc_cap || $changed(cfg_q);
    endproperty
    a_cap: assert property (p_cap) else $error("charge above cap");
endmodule : scm_top

// >>> test/scm_operator.sv
// scm_operator: operator model for switches, jumper, store button, pot and levers
// assumes the bench calls its tasks; every drive lands just after a sys_clk edge
`timescale 1ns/1ps
module scm_operator (
    input  wire logic sys_clk,
    output logic [6:0] config_switch_bank,
    output logic       setup_jumper,
    output logic       store_pushbutton,
    output logic [7:0] adjust_potentiometer,
    output logic       station_cmd,
    output logic [1:0] lever_dir,
    output logic [7:0] lever_speed
);
    initial begin
        config_switch_bank   = 7'h00;
        setup_jumper         = 1'b0;
        store_pushbutton     = 1'b0;
        adjust_potentiometer = 8'h00;
        station_cmd          = 1'b0;
        lever_dir            = scm_pkg::DIR_NEUT;
        lever_speed          = 8'h00;
    end
    // pot first, then switches on from the highest number down
    task automatic set_pattern(input logic [6:0] p, input logic [7:0] v);
        @(posedge sys_clk);
        adjust_potentiometer <= v;
        for (int b = 6; b >= 0; b--) begin
            if (p[b]) begin
                @(posedge sys_clk);
                config_switch_bank <= config_switch_bank | 7'(1 << b);
            end
        end
    endtask : set_pattern
    task automatic clear_sw();
        @(posedge sys_clk);
        config_switch_bank   <= 7'h00;
        adjust_potentiometer <= 8'h00;
    endtask : clear_sw
    // command taken and levers at neutral before the jumper closes
    task automatic enter_setup();
        @(posedge sys_clk);
        station_cmd <= 1'b1;
        lever_dir   <= scm_pkg::DIR_NEUT;
        lever_speed <= 8'h00;
        repeat (2) @(posedge sys_clk);
        setup_jumper <= 1'b1;
    endtask : enter_setup
    task automatic leave_setup();
        @(posedge sys_clk);
        setup_jumper <= 1'b0;
        station_cmd  <= 1'b0;
    endtask : leave_setup
    task automatic jumper(input logic v);
        @(posedge sys_clk);
        setup_jumper <= v;
    endtask : jumper
    task automatic take_cmd(input logic v);
        @(posedge sys_clk);
        station_cmd <= v;
    endtask : take_cmd
    task automatic button(input logic v);
        @(posedge sys_clk);
        store_pushbutton <= v;
    endtask : button
    task automatic lever(input logic [1:0] d, input logic [7:0] s);
        @(posedge sys_clk);
        lever_dir   <= d;
        lever_speed <= s;
    endtask : lever
endmodule : scm_operator

// >>> test/testbench.sv
// testbench: set-up mode, parameter store, clutch window and reversal pause
// assumes scm_top with MS_DIV shortened; operator side from scm_operator
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module testbench;
    localparam int MSD = 2;
    logic              sys_clk = 1'b0;
    logic              reset;
    logic [6:0]        config_switch_bank;
    logic              setup_jumper;
    logic              store_pushbutton;
    logic [7:0]        adjust_potentiometer;
    logic              station_cmd;
    logic [1:0]        lever_dir;
    logic [7:0]        lever_speed;
    logic              clutch_sw_fitted;
    logic              clutch_sw_closed;
    logic [7:0]        reg_addr;
    logic [31:0]       reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    scm_pkg::scm_ind_t ind_q;
    logic              run_state_q;
    logic [7:0]        throttle_q;
    logic [1:0]        gear_q;
    scm_pkg::scm_cfg_t cfg_q;
    scm_pkg::scm_cfg_t expc;
    logic [31:0]       reg_rdata_q;
    logic [31:0]       d;
    logic [6:0]        pats [6];
    logic [7:0]        pots [6];
    logic [7:0]        spd;
    int                n_fail = 0;
    int                num_checks = 0;
    int                seed;
    int                tog;
    int                rise;
    int                hi;
    always #20 sys_clk = ~sys_clk;
    scm_top #(.MS_DIV(MSD)) i_scm_top (.sys_clk(sys_clk), .reset(reset),
        .config_switch_bank(config_switch_bank), .setup_jumper(setup_jumper),
        .store_pushbutton(store_pushbutton), .adjust_potentiometer(adjust_potentiometer),
        .station_cmd(station_cmd), .lever_dir(lever_dir), .lever_speed(lever_speed),
        .clutch_sw_fitted(clutch_sw_fitted), .clutch_sw_closed(clutch_sw_closed),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .ind_q(ind_q), .run_state_q(run_state_q), .throttle_q(throttle_q),
        .gear_q(gear_q), .cfg_q(cfg_q), .reg_rdata_q(reg_rdata_q));
    scm_operator i_scm_operator (.sys_clk(sys_clk), .config_switch_bank(config_switch_bank),
        .setup_jumper(setup_jumper), .store_pushbutton(store_pushbutton),
        .adjust_potentiometer(adjust_potentiometer), .station_cmd(station_cmd),
        .lever_dir(lever_dir), .lever_speed(lever_speed));
    function automatic scm_pkg::scm_cfg_t exp_cfg(input scm_pkg::scm_cfg_t c,
                                                  input logic [6:0] p, input logic [7:0] v);
        exp_cfg = c;
        case (p)
            scm_pkg::SEL_SCREWS:   exp_cfg.screws = v[7:6];
            scm_pkg::SEL_CPT_SHRT: exp_cfg.cpt_long = 1'b0;
            scm_pkg::SEL_CPT_LONG: exp_cfg.cpt_long = 1'b1;
            scm_pkg::SEL_CDLY:     exp_cfg.delay_s = (v[7:4] > 4'hC) ? 4'hC : v[7:4];
            default:               exp_cfg = c;
        endcase
    endfunction : exp_cfg
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step
    task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata_q;
    endtask : reg_read
    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    // counts relay toggles and rises and tone-on cycles over n cycles
    task automatic measure(input int n, output int t, output int r, output int h);
        logic prev;
        t = 0;
        r = 0;
        h = 0;
        prev = ind_q.relay;
        repeat (n) begin
            @(posedge sys_clk);
            #1;
            if (ind_q.relay !== prev) t++;
            if (ind_q.relay === 1'b1 && prev === 1'b0) r++;
            if (ind_q.tone === 1'b1) h++;
            prev = ind_q.relay;
        end
    endtask : measure
    task automatic complete_run();
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_fail++;
        complete_run();
    end
    initial begin
        seed = 32'ha6b7;
        reset = 1'b1;
        {clutch_sw_fitted, clutch_sw_closed, reg_wr, reg_rd} = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        pats = '{scm_pkg::SEL_SCREWS, scm_pkg::SEL_CPT_LONG, scm_pkg::SEL_CPT_SHRT,
                 scm_pkg::SEL_CDLY, scm_pkg::SEL_CDLY, scm_pkg::SEL_CDLY};
        pots = '{8'hC0, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h10};
        pots[3] = 8'($random(seed));
        expc = scm_pkg::CFG_DEF;
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        step(2);
        `CHK(run_state_q, 1'b1)
        `CHK(cfg_q, scm_pkg::CFG_DEF)
        reg_read(scm_pkg::REG_PARAM, d);
        `CHK(d, {25'h0, scm_pkg::CFG_DEF})
        reg_read(8'($random(seed)) | 8'hF0, d);
        `CHK(d, 32'h0)
        i_scm_operator.set_pattern(scm_pkg::SEL_SCREWS, 8'hC0);
        i_scm_operator.button(1'b1);
        step(20);
        `CHK(cfg_q, scm_pkg::CFG_DEF)
        `CHK(ind_q.relay, 1'b0)
        i_scm_operator.button(1'b0);
        i_scm_operator.clear_sw();
        i_scm_operator.enter_setup();
        step(4);
        `CHK(ind_q.tone, 1'b1)
        `CHK(ind_q.lamp, 1'b0)
        `CHK(ind_q.run_led, 1'b0)
        `CHK(run_state_q, 1'b0)
        step(2990 * MSD - 4);
        `CHK(ind_q.tone, 1'b1)
        `CHK(ind_q.run_led, 1'b0)
        step(20 * MSD);
        `CHK(ind_q.tone, 1'b0)
        for (int i = 0; i < 6; i++) begin
            i_scm_operator.set_pattern(pats[i], pots[i]);
            step(8);
            i_scm_operator.button(1'b1);
            measure(150 * MSD, tog, rise, hi);
            expc = exp_cfg(expc, pats[i], pots[i]);
            `CHK(cfg_q, expc)
            `CHK(rise, 1)
            i_scm_operator.button(1'b0);
            i_scm_operator.clear_sw();
            step(8);
        end
        reg_read(scm_pkg::REG_PARAM, d);
        `CHK(d, {25'h0, expc})
        i_scm_operator.set_pattern(7'h03, 8'h00);
        measure(1000 * MSD, tog, rise, hi);
        `CHK(tog >= 2, 1'b1)
        `CHK(hi > 900 * MSD, 1'b1)
        i_scm_operator.button(1'b1);
        step(8);
        `CHK(cfg_q, expc)
        i_scm_operator.button(1'b0);
        i_scm_operator.clear_sw();
        i_scm_operator.leave_setup();
        step(4);
        measure(1000 * MSD, tog, rise, hi);
        `CHK(hi > 50 * MSD && hi < 200 * MSD, 1'b1)
        `CHK(ind_q.lamp, 1'b0)
        i_scm_operator.take_cmd(1'b1);
        step(4);
        `CHK(ind_q.lamp, 1'b1)
        `CHK(run_state_q, 1'b1)
        reg_read(scm_pkg::REG_STATUS, d);
        `CHK(d, {24'h000000, 3'b001, scm_pkg::ST_RUN})
        i_scm_operator.set_pattern(scm_pkg::SEL_SCREWS, 8'h00);
        i_scm_operator.jumper(1'b1);
        measure(600 * MSD, tog, rise, hi);
        `CHK(tog >= 2, 1'b1)
        i_scm_operator.jumper(1'b0);
        i_scm_operator.clear_sw();
        step(4);
        `CHK(run_state_q, 1'b1)
        measure(300 * MSD, tog, rise, hi);
        `CHK(tog, 0)
        @(posedge sys_clk);
        clutch_sw_fitted <= 1'b1;
        spd = 8'($random(seed)) | 8'h01;
        i_scm_operator.lever(scm_pkg::DIR_AHEAD, spd);
        step(400 * MSD);
        `CHK(throttle_q, spd)
        `CHK(gear_q, scm_pkg::DIR_AHEAD)
        step(200 * MSD);
        `CHK(throttle_q, 8'h00)
        i_scm_operator.lever(scm_pkg::DIR_NEUT, 8'h00);
        clutch_sw_closed <= 1'b1;
        i_scm_operator.lever(scm_pkg::DIR_AHEAD, spd);
        step(700 * MSD);
        `CHK(throttle_q, spd)
        i_scm_operator.lever(scm_pkg::DIR_NEUT, 8'h00);
        i_scm_operator.lever(scm_pkg::DIR_AHEAD, 8'h00);
        step(100 * MSD);
        i_scm_operator.lever(scm_pkg::DIR_ASTERN, 8'h00);
        step(4);
        `CHK(gear_q, scm_pkg::DIR_ASTERN)
        i_scm_operator.lever(scm_pkg::DIR_AHEAD, 8'hFF);
        step(7000 * MSD);
        i_scm_operator.lever(scm_pkg::DIR_ASTERN, 8'hFF);
        step(900 * MSD);
        `CHK(gear_q, scm_pkg::DIR_AHEAD)
        `CHK(throttle_q, 8'h00)
        step(150 * MSD);
        `CHK(gear_q, scm_pkg::DIR_ASTERN)
        `CHK(throttle_q, 8'hFF)
        step(7000 * MSD);
        i_scm_operator.lever(scm_pkg::DIR_AHEAD, 8'hFF);
        step(450 * MSD);
        `CHK(gear_q, scm_pkg::DIR_ASTERN)
        step(100 * MSD);
        `CHK(gear_q, scm_pkg::DIR_AHEAD)
        reg_write(scm_pkg::REG_CTRL, {31'($random(seed)), 1'b0});
        step(2);
        `CHK(cfg_q, expc)
        reg_write(scm_pkg::REG_CTRL, {31'($random(seed)), 1'b1});
        step(2);
        `CHK(cfg_q, scm_pkg::CFG_DEF)
        complete_run();
    end
endmodule : testbench
